// ### hdl/uhpr_params.svh
// Constants for the USB host port router
`ifndef UHPR_PARAMS_SVH
`define UHPR_PARAMS_SVH

`define UHPR_NPORTS   3       // host ports behind the router
`define UHPR_PSEL_W   2       // width of a port number
`define UHPR_DW       8       // link data width
`define UHPR_MODE_W   2       // width of a port mode code
`define UHPR_PORT3    2       // index of the third port
`define UHPR_NCLK     2       // ports 1 and 2 may feed an external PHY clock
`define UHPR_TXCMD    4'h4    // upper nibble of a transmit command byte
`define UHPR_BUF_N    2       // entries of each port buffer
`define UHPR_CNT_W    2       // width of a buffer fill count

`endif

// ### hdl/uhpr_pkg.sv
// Types shared by the USB host port router modules
`default_nettype none

package uhpr_pkg;
   // Port operating modes, as driven on the configuration inputs
   typedef enum logic [1:0] {
      UHPR_MODE_SERIAL = 2'h0,
      UHPR_MODE_ULPI   = 2'h1,
      UHPR_MODE_XCL    = 2'h2
   } uhpr_mode_t;

   // Transmit framing state of the transceiverless converter
   typedef enum logic {
      UHPR_XCL_HEAD,
      UHPR_XCL_BODY
   } uhpr_xcl_st_t;
endpackage

`default_nettype wire

// ### hdl/uhpr_stream_if.sv
// Byte stream carrier between the router's own modules
`include "uhpr_params.svh"
`default_nettype none

interface uhpr_stream_if;
   logic                valid;
   logic                ready;
   logic                last;
   logic [`UHPR_DW-1:0] data;

   modport src (output valid, output last, output data, input ready);
   modport snk (input valid, input last, input data, output ready);
endinterface

`default_nettype wire

// ### hdl/uhpr_tll_conv.sv
// Transceiverless converter: packet stream to ULPI transmit format
`include "uhpr_params.svh"
`default_nettype none

module uhpr_xcl_conv (
   input  wire logic    core_clk,
   input  wire logic    sys_rst,
   input  wire logic    bypass,
   uhpr_stream_if.snk   up,
   uhpr_stream_if.src   dn
);
   uhpr_pkg::uhpr_xcl_st_t state_r;
   uhpr_pkg::uhpr_xcl_st_t state_nxt;
   logic                   head;
   logic                   moved;

   // ------------------------------------------------------------
   // Byte substitution
   // ------------------------------------------------------------
   // First byte carries the PID; it becomes a transmit command byte
   assign head      = !bypass && (state_r == uhpr_pkg::UHPR_XCL_HEAD);
   assign dn.valid  = up.valid;
   assign dn.last   = up.last;
   assign dn.data   = head ? {`UHPR_TXCMD, up.data[3:0]} : up.data;
   assign up.ready  = dn.ready;
   assign moved     = up.valid && dn.ready;
   assign state_nxt = (moved && up.last) ? uhpr_pkg::UHPR_XCL_HEAD :
                      moved ? uhpr_pkg::UHPR_XCL_BODY : state_r;

   // Packet framing state
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_r <= uhpr_pkg::UHPR_XCL_HEAD;
      end else begin
         state_r <= state_nxt;
      end
   end

   a_xcl_head_cmd: assert property (@(posedge core_clk) disable iff (sys_rst)
      (moved && !bypass && $past(moved && up.last)) |-> dn.data[7:4] == `UHPR_TXCMD)
      else $error("converter sent a packet without a command byte");
endmodule // uhpr_xcl_conv

`default_nettype wire

// ### hdl/uhpr_otg_link.sv
// OTG port link: ULPI pins on the PHY clock, crossings to core clock
`include "uhpr_params.svh"
`default_nettype none

module uhpr_otg_link (
   input  wire logic                core_clk,
   input  wire logic                sys_rst,
   uhpr_stream_if.snk               tx,
   output logic                     rxValid,
   output logic [`UHPR_DW-1:0]      rxData,
   input  wire logic                ulpiClk,
   input  wire logic                ulpiDir,
   input  wire logic                ulpiNxt,
   input  wire logic [`UHPR_DW-1:0] ulpiDataIn,
   output logic [`UHPR_DW-1:0]      ulpiDataOut,
   output logic                     ulpiDataOe,
   output logic                     ulpiStp
);
   logic                busy_r, req_r, holdLast_r, ackMeta_r, ackSync_r;
   logic [`UHPR_DW-1:0] holdData_r, rxByte_r;
   logic                rxMeta_r, rxSync_r, rxSeen_r;
   logic                rstMeta_r, linkRst_r, reqMeta_r, reqSync_r;
   logic                reqSeen_r, ack_r, stp_r, dirPrev_r, rxTog_r;
   logic                pending, sent, rxTake;

   // ------------------------------------------------------------
   // Core side: hold one byte until the link acknowledges it
   // ------------------------------------------------------------
   assign tx.ready = !busy_r;
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         busy_r     <= 1'b0;
         req_r      <= 1'b0;
         holdData_r <= '0;
         holdLast_r <= 1'b0;
      end else if (tx.valid && !busy_r) begin
         holdData_r <= tx.data;
         holdLast_r <= tx.last;
         req_r      <= !req_r;
         busy_r     <= 1'b1;
      end else if (busy_r && ackSync_r == req_r) begin
         busy_r <= 1'b0;
      end
   end

   // Core side synchronisers and receive pulse
   always_ff @(posedge core_clk) begin
      ackMeta_r <= ack_r;
      ackSync_r <= ackMeta_r;
      rxMeta_r  <= rxTog_r;
      rxSync_r  <= rxMeta_r;
      if (sys_rst) begin
         rxSeen_r <= 1'b0;
         rxValid  <= 1'b0;
         rxData   <= '0;
      end else begin
         rxSeen_r <= rxSync_r;
         rxValid  <= rxSync_r != rxSeen_r;
         if (rxSync_r != rxSeen_r) begin
            rxData <= rxByte_r;
         end
      end
   end

   // ------------------------------------------------------------
   // Link side, clocked by the PHY
   // ------------------------------------------------------------
   // Drive only after a turnaround cycle with the PHY not driving
   assign pending     = reqSync_r != reqSeen_r;
   assign ulpiDataOe  = pending && !ulpiDir && !dirPrev_r;
   assign ulpiDataOut = holdData_r;
   assign ulpiStp     = stp_r;
   assign sent        = ulpiDataOe && ulpiNxt;
   assign rxTake      = ulpiDir && dirPrev_r && ulpiNxt;

   // Reset and request synchronisers into the PHY clock
   always_ff @(posedge ulpiClk) begin
      rstMeta_r <= sys_rst;
      linkRst_r <= rstMeta_r;
      reqMeta_r <= req_r;
      reqSync_r <= reqMeta_r;
   end

   // Receive bytes rely on the PHY spacing them; a dense burst may be lost
   always_ff @(posedge ulpiClk) begin
      if (linkRst_r) begin
         reqSeen_r <= 1'b0;
         ack_r     <= 1'b0;
         stp_r     <= 1'b0;
         dirPrev_r <= 1'b0;
         rxTog_r   <= 1'b0;
         rxByte_r  <= '0;
      end else begin
         dirPrev_r <= ulpiDir;
         stp_r     <= sent && holdLast_r;
         if (sent) begin
            reqSeen_r <= reqSync_r;
            ack_r     <= reqSync_r;
         end
         if (rxTake) begin
            rxByte_r <= ulpiDataIn;
            rxTog_r  <= !rxTog_r;
         end
      end
   end

   a_stp_after_last: assert property (@(posedge ulpiClk) disable iff (linkRst_r)
      (sent && holdLast_r) |=> ulpiStp ##1 !ulpiStp)
      else $error("stop not pulsed after last byte");
endmodule // uhpr_otg_link

`default_nettype wire

// ### hdl/uhpr_port_router.sv
// USB host port router: port ownership, modes, XCL and OTG link
//
// Behaviour
// - Each host port belongs to exactly one controller, never both.
// - EHCI carries high-speed traffic only on ULPI or XCL ports.
// - OHCI carries full/low-speed traffic on serial-interface ports.
// - Both controllers run at once, each on its own ports.
// - An XCL port turns the internal stream into ULPI transmit format.
// - On revision 1.0, any ULPI port forces one shared configuration.
// - The third port never runs ULPI; only serial or XCL.
// - ULPI ports 1 and 2 are high-speed only; OHCI cannot own them.
// - OTG port reaches its PHY over 12-pin, 8-bit SDR ULPI.
`include "uhpr_params.svh"
`default_nettype none

module uhpr_port_router (
   input  wire logic                          core_clk,
   input  wire logic                          sys_rst,
   input  wire logic                          revOnePin,
   input  wire logic                          cfgApply,
   input  wire logic [`UHPR_NPORTS-1:0]       cfgOwnOhci,
   input  wire logic [2*`UHPR_NPORTS-1:0]     cfgMode,
   input  wire logic [`UHPR_NPORTS-1:0]       portIdle,
   output logic                               cfgReject,
   output logic [`UHPR_NPORTS-1:0]            ownOhci,
   output logic [`UHPR_NPORTS-1:0]            portHighSpeed,
   output logic [2*`UHPR_NPORTS-1:0]          portMode,
   input  wire logic                          ehciValid,
   output logic                               ehciReady,
   input  wire logic [`UHPR_DW-1:0]           ehciData,
   input  wire logic                          ehciLast,
   input  wire logic [`UHPR_PSEL_W-1:0]       ehciPort,
   output logic                               ehciDrop,
   output logic [`UHPR_NPORTS-1:0]            portTxValid,
   input  wire logic [`UHPR_NPORTS-1:0]       portTxReady,
   output logic [`UHPR_DW*`UHPR_NPORTS-1:0]   portTxData,
   output logic [`UHPR_NPORTS-1:0]            portTxLast,
   input  wire logic [`UHPR_NPORTS-1:0]       ohciSerTx,
   input  wire logic [`UHPR_NPORTS-1:0]       ohciSerOe,
   output logic [`UHPR_NPORTS-1:0]            portSerTx,
   output logic [`UHPR_NPORTS-1:0]            portSerOe,
   output logic [`UHPR_NCLK-1:0]              phyRefClk,
   input  wire logic                          otgTxValid,
   output logic                               otgTxReady,
   input  wire logic [`UHPR_DW-1:0]           otgTxData,
   input  wire logic                          otgTxLast,
   output logic                               otgRxValid,
   output logic [`UHPR_DW-1:0]                otgRxData,
   input  wire logic                          otgUlpiClk,
   input  wire logic                          otgUlpiDir,
   input  wire logic                          otgUlpiNxt,
   input  wire logic [`UHPR_DW-1:0]           otgUlpiDataIn,
   output logic [`UHPR_DW-1:0]                otgUlpiDataOut,
   output logic                               otgUlpiDataOe,
   output logic                               otgUlpiStp
);
   // ------------------------------------------------------------
   // Decoding helpers
   // ------------------------------------------------------------
   // Mode code of port i within a packed mode vector
   function automatic logic [`UHPR_MODE_W-1:0] modeAt(
      input logic [2*`UHPR_NPORTS-1:0] f,
      input int                        i
   );
      modeAt = f[`UHPR_MODE_W*i +: `UHPR_MODE_W];
   endfunction

   // True when the mode code equals the given mode
   function automatic logic isMode(
      input logic [`UHPR_MODE_W-1:0] m,
      input uhpr_pkg::uhpr_mode_t    want
   );
      isMode = (m == want);
   endfunction

   logic                          revMeta_r, revOne_r;
   logic [`UHPR_NPORTS-1:0]       ulpiNew, portBad, changed;
   logic [`UHPR_NPORTS-1:0]       ulpiMask, hsPath, serPath;
   logic [`UHPR_NPORTS-1:0]       upValid, upReady;
   logic                          rev10Bad, blocked, cfgOk, pathOk;
   logic [`UHPR_NCLK-1:0]         phyClk_r;
   logic                          drop_r;

   // ------------------------------------------------------------
   // Strap synchroniser
   // ------------------------------------------------------------
   // Revision strap is a pin: two flops before anything reads it
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         revMeta_r <= 1'b0;
         revOne_r  <= 1'b0;
      end else begin
         revMeta_r <= revOnePin;
         revOne_r  <= revMeta_r;
      end
   end

   // ------------------------------------------------------------
   // Configuration check and apply
   // ------------------------------------------------------------
   // Per-port legality of the requested configuration
   generate
      for (genvar p = 0; p < `UHPR_NPORTS; p++) begin : g_chk
         logic [`UHPR_MODE_W-1:0] nm;
         assign nm         = modeAt(cfgMode, p);
         assign ulpiNew[p] = isMode(nm, uhpr_pkg::UHPR_MODE_ULPI);
         assign portBad[p] =
            (ulpiNew[p] && cfgOwnOhci[p])
            || (ulpiNew[p] && p == `UHPR_PORT3)
            || (isMode(nm, uhpr_pkg::UHPR_MODE_SERIAL)
                && !cfgOwnOhci[p])
            || (!isMode(nm, uhpr_pkg::UHPR_MODE_SERIAL) && !ulpiNew[p]
                && !isMode(nm, uhpr_pkg::UHPR_MODE_XCL));
         assign changed[p] = (cfgOwnOhci[p] != ownOhci[p])
                             || (nm != modeAt(portMode, p));
      end
   endgenerate

   // Early silicon: one ULPI port drags every port to high-speed
   assign rev10Bad = revOne_r && (|ulpiNew) && (|cfgOwnOhci);
   // A busy port must not change under its traffic
   assign blocked  = |(changed & ~portIdle);
   assign cfgOk    = !(|portBad) && !rev10Bad && !blocked;

   // One owner bit per port makes shared ownership impossible
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ownOhci   <= '1;
         portMode  <= '0;
         cfgReject <= 1'b0;
      end else begin
         cfgReject <= cfgApply && !cfgOk;
         if (cfgApply && cfgOk) begin
            ownOhci  <= cfgOwnOhci;
            portMode <= cfgMode;
         end
      end
   end

   // ------------------------------------------------------------
   // Per-port paths
   // ------------------------------------------------------------
   generate
      for (genvar p = 0; p < `UHPR_NPORTS; p++) begin : g_port
         logic [`UHPR_MODE_W-1:0] cm;
         logic [`UHPR_DW-1:0]     bufData_r [`UHPR_BUF_N];
         logic                    bufLast_r [`UHPR_BUF_N];
         logic                    wrPtr_r, rdPtr_r;
         logic [`UHPR_CNT_W-1:0]  cnt_r;
         logic                    push, pop;
         uhpr_stream_if           upIf ();
         uhpr_stream_if           xclIf ();

         // Path selection by owner and mode
         assign cm          = modeAt(portMode, p);
         assign ulpiMask[p] = isMode(cm, uhpr_pkg::UHPR_MODE_ULPI);
         assign hsPath[p]   = !ownOhci[p] && (ulpiMask[p]
                              || isMode(cm, uhpr_pkg::UHPR_MODE_XCL));
         assign serPath[p]  = ownOhci[p]
                              && isMode(cm, uhpr_pkg::UHPR_MODE_SERIAL);

         // EHCI stream reaches only the addressed high-speed port
         assign upIf.valid = ehciValid && hsPath[p]
                             && ehciPort == `UHPR_PSEL_W'(p);
         assign upIf.data  = ehciData;
         assign upIf.last  = ehciLast;
         assign upValid[p] = upIf.valid;
         assign upReady[p] = upIf.ready;

         // ULPI ports pass bytes straight; XCL ports get framed
         uhpr_xcl_conv u_xcl (
            .core_clk (core_clk),
            .sys_rst  (sys_rst),
            .bypass   (ulpiMask[p]),
            .up       (upIf),
            .dn       (xclIf)
         );

         // Two-entry buffer so a stalled port loses no byte
         assign xclIf.ready    = cnt_r != `UHPR_CNT_W'(`UHPR_BUF_N);
         assign push           = xclIf.valid && xclIf.ready;
         assign pop            = portTxValid[p] && portTxReady[p];
         assign portTxValid[p] = cnt_r != '0;
         assign portTxData[`UHPR_DW*p +: `UHPR_DW] = bufData_r[rdPtr_r];
         assign portTxLast[p]  = bufLast_r[rdPtr_r];

         // Buffer pointers and storage
         always_ff @(posedge core_clk) begin
            if (sys_rst) begin
               wrPtr_r <= 1'b0;
               rdPtr_r <= 1'b0;
               cnt_r   <= '0;
               bufData_r[0] <= '0;
               bufData_r[1] <= '0;
               bufLast_r[0] <= 1'b0;
               bufLast_r[1] <= 1'b0;
            end else begin
               if (push) begin
                  bufData_r[wrPtr_r] <= xclIf.data;
                  bufLast_r[wrPtr_r] <= xclIf.last;
                  wrPtr_r            <= !wrPtr_r;
               end
               if (pop) begin
                  rdPtr_r <= !rdPtr_r;
               end
               cnt_r <= cnt_r + `UHPR_CNT_W'(push) - `UHPR_CNT_W'(pop);
            end
         end

         // OHCI serial lines run independently of EHCI traffic
         always_ff @(posedge core_clk) begin
            if (sys_rst) begin
               portSerTx[p]     <= 1'b0;
               portSerOe[p]     <= 1'b0;
               portHighSpeed[p] <= 1'b0;
            end else begin
               portSerTx[p]     <= ohciSerTx[p] && serPath[p];
               portSerOe[p]     <= ohciSerOe[p] && serPath[p];
               portHighSpeed[p] <= !ownOhci[p];
            end
         end
      end

      // Reference clock for external PHYs on ports 1 and 2
      for (genvar c = 0; c < `UHPR_NCLK; c++) begin : g_clk
         always_ff @(posedge core_clk) begin
            if (sys_rst) begin
               phyClk_r[c] <= 1'b0;
            end else begin
               phyClk_r[c] <= ulpiMask[c] && !phyClk_r[c];
            end
         end
      end
   endgenerate

   assign phyRefClk = phyClk_r;

   // ------------------------------------------------------------
   // EHCI handshake
   // ------------------------------------------------------------
   // Bytes for an unusable port are swallowed so EHCI never hangs
   assign pathOk    = ehciPort < `UHPR_PSEL_W'(`UHPR_NPORTS)
                      && hsPath[ehciPort];
   assign ehciReady = pathOk ? upReady[ehciPort] : 1'b1;
   assign ehciDrop  = drop_r;

   // Drop indication, one pulse per discarded byte
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         drop_r <= 1'b0;
      end else begin
         drop_r <= ehciValid && !pathOk;
      end
   end

   // ------------------------------------------------------------
   // OTG port
   // ------------------------------------------------------------
   uhpr_stream_if otgIf ();
   assign otgIf.valid = otgTxValid;
   assign otgIf.data  = otgTxData;
   assign otgIf.last  = otgTxLast;
   assign otgTxReady  = otgIf.ready;

   // PHY drives the ULPI clock; this side only receives it
   uhpr_otg_link u_otg (
      .core_clk    (core_clk),
      .sys_rst     (sys_rst),
      .tx          (otgIf),
      .rxValid     (otgRxValid),
      .rxData      (otgRxData),
      .ulpiClk     (otgUlpiClk),
      .ulpiDir     (otgUlpiDir),
      .ulpiNxt     (otgUlpiNxt),
      .ulpiDataIn  (otgUlpiDataIn),
      .ulpiDataOut (otgUlpiDataOut),
      .ulpiDataOe  (otgUlpiDataOe),
      .ulpiStp     (otgUlpiStp)
   );

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   a_owner_exclusive: assert property (
      (upValid & ownOhci) == '0 && (portSerOe & ~$past(ownOhci)) == '0)
      else $error("port driven by a controller that does not own it");

   a_hs_drop: assert property (
      (ehciValid && !pathOk) |-> ehciReady ##1 ehciDrop)
      else $error("byte for a non high-speed port not dropped");

   a_serial_route: assert property (
      (|(ohciSerOe & serPath)) |=> portSerOe == $past(ohciSerOe & serPath))
      else $error("serial enable not routed to its port");

   a_parallel_run: assert property (
      (ehciValid && ehciReady) |=> portSerTx == $past(ohciSerTx & serPath))
      else $error("serial traffic disturbed by EHCI traffic");

   a_rev10_uniform: assert property (
      (cfgApply && revOne_r && (|ulpiNew) && (|cfgOwnOhci))
      |=> cfgReject && $stable(ownOhci))
      else $error("mixed configuration with a ULPI port on early silicon");

   a_port3_no_ulpi: assert property (
      !ulpiMask[`UHPR_PORT3])
      else $error("third port placed in ULPI mode");

   a_ref_clock: assert property (
      ulpiMask[0] ##1 ulpiMask[0] |-> phyRefClk[0] != $past(phyRefClk[0]))
      else $error("reference clock to port 1 PHY not toggling");

   a_cfg_hold: assert property (
      (cfgApply && blocked) |=> $stable(ownOhci) && $stable(portMode)
                                && cfgReject)
      else $error("configuration changed under an active port");
endmodule // uhpr_port_router

`default_nettype wire

// ### verif/uhpr_phy_model.sv
// Behavioural ULPI PHY standing on the OTG link
`default_nettype none

module uhpr_phy_model (
   output logic            otgUlpiClk,
   output logic            otgUlpiDir,
   output logic            otgUlpiNxt,
   output logic [7:0]      otgUlpiDataIn,
   input  wire logic [7:0] otgUlpiDataOut,
   input  wire logic       otgUlpiDataOe,
   input  wire logic       otgUlpiStp
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] txSeen = 8'h00;
   logic       stpSeen = 1'b0;
   int         holdOff = 0, waitCnt = 0;
   wire        offer = otgUlpiDataOe === 1'b1 && !otgUlpiNxt;
   // Link clock comes from this side, free running, off phase
   initial begin
      {otgUlpiClk, otgUlpiDir, otgUlpiNxt, otgUlpiDataIn} = 11'h000;
      #3.3;
      forever #6 otgUlpiClk = ~otgUlpiClk;
   end
   // Accept after holdOff cycles; bus not ours toggles so stale data shows
   always @(posedge otgUlpiClk) begin
      stpSeen <= stpSeen | (otgUlpiStp === 1'b1);
      if (!otgUlpiDir) begin
         otgUlpiDataIn <= ~otgUlpiDataIn;
         otgUlpiNxt <= offer && waitCnt >= holdOff;
         waitCnt <= offer && waitCnt < holdOff ? waitCnt + 1 : 0;
         if (offer) txSeen <= otgUlpiDataOut;
      end
   end
   // One received byte: turnaround, data with nxt, turn back, spacing
   task automatic sendRx(input logic [7:0] d);
      @(posedge otgUlpiClk) otgUlpiDir <= 1'b1;
      @(posedge otgUlpiClk) {otgUlpiNxt, otgUlpiDataIn} <= {1'b1, d};
      @(posedge otgUlpiClk) otgUlpiNxt <= 1'b0;
      @(posedge otgUlpiClk) otgUlpiDir <= 1'b0;
      repeat (3) @(posedge otgUlpiClk);
   endtask
endmodule // uhpr_phy_model

`default_nettype wire

// ### verif/uhpr_port_router_tb.sv
// Self-checking bench for the USB host port router
`default_nettype none

module uhpr_port_router_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk, sys_rst, revOnePin, cfgApply, cfgReject, stallRnd;
   logic        ehciValid, ehciReady, ehciLast, ehciDrop, otgTxValid;
   logic        otgTxReady, otgTxLast, otgRxValid, otgUlpiClk, otgUlpiDir;
   logic        otgUlpiNxt, otgUlpiDataOe, otgUlpiStp;
   logic [2:0]  cfgOwnOhci, portIdle, ownOhci, portHighSpeed, portTxValid;
   logic [2:0]  portTxReady, portTxLast, ohciSerTx, ohciSerOe, portSerTx;
   logic [2:0]  portSerOe;
   logic [5:0]  cfgMode, portMode;
   logic [1:0]  ehciPort, phyRefClk;
   logic [7:0]  ehciData, otgTxData, otgRxData, otgUlpiDataIn, b;
   logic [7:0]  otgUlpiDataOut;
   logic [23:0] portTxData;
   logic [31:0] seed = 32'h4951;
   logic [8:0]  txQ[$], rxQ[$];
   int          fail_count = 0, n_tests = 0, k = 0;

   uhpr_port_router u_dut (.*);
   uhpr_phy_model   u_phy (.*);

   // Core clock, 10 ns
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // Helpers: xorshift source, compare, verdict, bounded-wait check
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   task automatic chk(input string nm, input logic [8:0] e, g);
      n_tests++;
      if (g !== e) begin
         $display("[FAIL] %s exp %h got %h", nm, e, g);
         fail_count++;
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic tmo();
      if (k < 99) return;
      chk("wait", 9'h001, 9'h000);
      print_verdict();
   endtask
   // Config pulse; refusal or update shows at the taking edge, checked half a cycle later
   task automatic cfg(input logic [2:0] o, logic [5:0] m, logic r);
      @(negedge core_clk);
      {cfgOwnOhci, cfgMode, cfgApply} = {o, m, 1'b1};
      @(negedge core_clk);
      cfgApply = 1'b0;
      chk("cfgReject", {8'h00, r}, {8'h00, cfgReject});
   endtask
   // Valid held from one call to the next, so no double drive per step
   task automatic ehci(input logic [1:0] p, logic [7:0] d, logic l);
      @(negedge core_clk);
      {ehciValid, ehciPort, ehciData, ehciLast} = {1'b1, p, d, l};
      for (k = 0; k < 99 && ehciReady !== 1'b1; k++) @(negedge core_clk);
      tmo();
      @(posedge core_clk);
   endtask
   // Random receiver stall on port 0
   always @(negedge core_clk) if (stallRnd) portTxReady <= {2'h3, ^rnd()};
   // Watcher: oldest note against each delivered byte
   always @(posedge core_clk) begin
      if (portTxValid[0] === 1'b1 && portTxReady[0] === 1'b1)
         chk("portTx0", txQ.size() ? txQ.pop_front() : 9'h1ff,
             {portTxLast[0], portTxData[7:0]});
      if (otgRxValid === 1'b1)
         chk("otgRx", rxQ.size() ? rxQ.pop_front() : 9'h1ff,
             {1'b0, otgRxData});
   end
   // Main sequence
   initial begin
      {sys_rst, revOnePin, cfgApply, ehciValid, ehciLast} = 5'h10;
      {otgTxValid, otgTxLast, stallRnd, cfgOwnOhci, portIdle} = 9'h03f;
      {portTxReady, ohciSerTx, ohciSerOe, cfgMode} = 15'h7000;
      {ehciPort, ehciData, otgTxData} = 18'h00000;
      repeat (2) @(negedge core_clk);
      sys_rst = 1'b0;
      chk("ownOhci", 9'h007, {6'h00, ownOhci});
      cfg(3'h4, 6'h06, 1'b0);
      chk("portMode", 9'h006, {3'h0, portMode});
      @(negedge core_clk);
      chk("portHighSpeed", 9'h003, {6'h00, portHighSpeed});
      b[1:0] = phyRefClk;
      @(negedge core_clk);
      chk("phyRefClk", {7'h00, ~b[1], 1'b0}, {7'h00, phyRefClk});
      cfg(3'h0, 6'h16, 1'b1);
      cfg(3'h6, 6'h06, 1'b1);
      cfg(3'h4, 6'h07, 1'b1);
      portIdle = 3'h3;
      cfg(3'h0, 6'h26, 1'b1);
      {portIdle, revOnePin} = 4'hf;
      repeat (3) @(negedge core_clk);
      cfg(3'h4, 6'h06, 1'b1);
      revOnePin = 1'b0;
      chk("ownOhci", 9'h004, {6'h00, ownOhci});
      $display("test config done");
      portTxReady[0] = 1'b0;
      for (int i = 0; i < 6; i++) begin
         if (i == 2) begin
            @(negedge core_clk);
            chk("ehciReady", 9'h000, {8'h00, ehciReady});
            stallRnd = 1'b1;
         end
         b = rnd();
         ehci(2'h0, b, i % 3 == 2);
         txQ.push_back({i % 3 == 2, i % 3 == 0 ? {4'h4, b[3:0]} : b});
      end
      b = rnd();
      ehci(2'h1, b, 1'b1);
      @(negedge core_clk);
      ehciValid = 1'b0;
      chk("portTx1", {1'b1, b}, {portTxLast[1], portTxData[15:8]});
      ehci(2'h2, 8'h5a, 1'b1);
      @(negedge core_clk);
      ehciValid = 1'b0;
      chk("ehciDrop", 9'h001, {8'h00, ehciDrop});
      stallRnd = 1'b0;
      repeat (2) @(negedge core_clk);
      {portTxReady, ohciSerTx, ohciSerOe} = 9'h1ef;
      repeat (9) @(negedge core_clk);
      chk("txQ", 9'h000, 9'(txQ.size()));
      chk("portSer", 9'h024, {3'h0, portSerTx, portSerOe});
      $display("test stream done");
      u_phy.holdOff = 3;
      b = rnd();
      @(negedge core_clk);
      {otgTxValid, otgTxData, otgTxLast} = {1'b1, b, 1'b1};
      for (k = 0; k < 99 && otgTxReady !== 1'b1; k++) @(negedge core_clk);
      tmo();
      @(negedge core_clk);
      otgTxValid = 1'b0;
      @(negedge core_clk);
      for (k = 0; k < 99 && otgTxReady !== 1'b1; k++) @(negedge core_clk);
      tmo();
      chk("otgTx", {1'b1, b}, {u_phy.stpSeen, u_phy.txSeen});
      for (int i = 0; i < 2; i++) begin
         b = rnd();
         rxQ.push_back({1'b0, b});
         u_phy.sendRx(b);
      end
      repeat (9) @(negedge core_clk);
      chk("rxQ", 9'h000, 9'(rxQ.size()));
      $display("test otg done");
      print_verdict();
   end
endmodule // uhpr_port_router_tb

`default_nettype wire
